/* bench/cmbi_mem_model.sv */
// memory model: upper address latch plus static memory
// assumes the bench resolves the shared data bus
`timescale 1ns/1ps
`default_nettype none
module cmbi_mem_model (
  input wire logic [7:0] lines_in,
  input wire logic latch_pulse_in,
  input wire logic read_n_in,
  input wire logic write_n_in,
  input wire logic [7:0] bus_in,
  output logic [7:0] mem_data_out,
  output logic mem_drive_out
);
  logic [7:0] hi_q = 8'h00;
  logic [7:0] mem [logic [15:0]];
  // capture upper byte on trailing edge, full eight bits
  always @(negedge latch_pulse_in) hi_q = lines_in;
  // store bus byte at end of low write pulse
  always @(posedge write_n_in) begin
    if (!$isunknown(lines_in)) mem[{hi_q, lines_in}] = bus_in;
  end
  // drive only while read strobe low, float during write
  assign mem_drive_out = (read_n_in === 1'b0);
  always @* begin
    mem_data_out = mem.exists({hi_q, lines_in}) ? mem[{hi_q, lines_in}] : 8'h5a;
  end
endmodule
`default_nettype wire

/* bench/tb_cpu_memory_bus_interface.sv */
// testbench: writes then reads back through the memory model
// assumes cmbi_pkg and the model are compiled first
`timescale 1ns/1ps
`default_nettype none
module tb_cpu_memory_bus_interface;
  logic clk_sys_in = 1'b0, rst_in = 1'b1, req_in = 1'b0;
  cmbi_pkg::cmbi_op_t op_in = cmbi_pkg::CMBI_OP_NONE, cur_op = cmbi_pkg::CMBI_OP_NONE;
  cmbi_pkg::cmbi_dst_t dst_in = cmbi_pkg::CMBI_DST_INT;
  logic [15:0] addr_in = 16'h0000, cur_addr = 16'h0000;
  logic [7:0] wdata_in = 8'h00, cur_wdata = 8'h00, mem_data;
  logic busy_out, address_latch_pulse_out, memory_read_enable_n_out, mem_drive;
  logic memory_write_strobe_n_out, bus_data_oe_n_out, int_valid_out, io_valid_out;
  logic [7:0] multiplexed_address_lines_out, bus_data_out, int_data_out, io_data_out;
  int mismatches = 0, tests_run = 0, seed = 57, i;
  logic [8:0] exp_q [$];
  logic [15:0] a [8];
  logic [7:0] d [8];
  // pull-ups hold the bus high when nobody drives
  wire [7:0] bus_data_in = !bus_data_oe_n_out ? bus_data_out : mem_drive ? mem_data : 8'hff;
  always #5 clk_sys_in = ~clk_sys_in;
  cmbi_mem_if uut (.clk_sys_in, .rst_in, .req_in, .op_in, .dst_in, .addr_in, .wdata_in,
    .bus_data_in, .busy_out, .multiplexed_address_lines_out, .address_latch_pulse_out,
    .memory_read_enable_n_out, .memory_write_strobe_n_out, .bus_data_out, .bus_data_oe_n_out,
    .int_data_out, .int_valid_out, .io_data_out, .io_valid_out);
  cmbi_mem_model mem_u (.lines_in(multiplexed_address_lines_out),
    .latch_pulse_in(address_latch_pulse_out), .read_n_in(memory_read_enable_n_out),
    .write_n_in(memory_write_strobe_n_out), .bus_in(bus_data_in),
    .mem_data_out(mem_data), .mem_drive_out(mem_drive));
  task automatic check(input logic [8:0] seen, input logic [8:0] exp);
    tests_run++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic tally_and_finish;
    $display("mismatches %0d tests_run %0d", mismatches, tests_run);
    if (mismatches == 0 && tests_run > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic run_cycle(input cmbi_pkg::cmbi_op_t op, input cmbi_pkg::cmbi_dst_t dst,
      input logic [15:0] ad, input logic [7:0] wd);
    int n;
    @(posedge clk_sys_in);
    #1;
    req_in = 1'b1; op_in = op; dst_in = dst; addr_in = ad; wdata_in = wd;
    @(posedge clk_sys_in);
    #1;
    req_in = 1'b0; cur_addr = ad; cur_op = op; cur_wdata = wd;
    n = 0;
    while (busy_out !== 1'b1 && n < 4) begin
      @(posedge clk_sys_in);
      #1;
      n++;
    end
    check({8'h00, busy_out}, 9'h001);
    while (busy_out !== 1'b0 && n < 20) begin
      @(posedge clk_sys_in);
      #1;
      n++;
    end
    if (n >= 20) begin
      mismatches++;
      tally_and_finish();
    end
  endtask
  // output watcher
  always @(posedge clk_sys_in) begin
    if (!rst_in) begin
      if (address_latch_pulse_out === 1'b1) check({1'b0, multiplexed_address_lines_out}, {1'b0, cur_addr[15:8]});
      if (memory_read_enable_n_out === 1'b0) check({1'b0, multiplexed_address_lines_out}, {1'b0, cur_addr[7:0]});
      if (memory_write_strobe_n_out === 1'b0) check({bus_data_oe_n_out, bus_data_out}, {1'b0, cur_wdata});
      if (cur_op == cmbi_pkg::CMBI_OP_NONE) check({7'h00, memory_read_enable_n_out, memory_write_strobe_n_out}, 9'h003);
      if (int_valid_out === 1'b1 || io_valid_out === 1'b1) begin
        if (exp_q.size() == 0) check(9'h1ff, 9'h000);
        else check({io_valid_out, io_valid_out ? io_data_out : int_data_out}, exp_q.pop_front());
      end
    end
  end
  initial begin
    repeat (6) @(posedge clk_sys_in);
    #1;
    rst_in = 1'b0;
    for (i = 0; i < 8; i++) begin
      a[i] = $random(seed);
      a[i][2:0] = i[2:0];
      d[i] = $random(seed);
      run_cycle(cmbi_pkg::CMBI_OP_WRITE, cmbi_pkg::CMBI_DST_INT, a[i], d[i]);
    end
    $display("test writes done");
    for (i = 0; i < 8; i++) begin
      exp_q.push_back({i[0], d[i]});
      run_cycle(cmbi_pkg::CMBI_OP_READ, i[0] ? cmbi_pkg::CMBI_DST_IO : cmbi_pkg::CMBI_DST_INT, a[i], 8'h00);
    end
    $display("test reads done");
    run_cycle(cmbi_pkg::CMBI_OP_NONE, cmbi_pkg::CMBI_DST_INT, a[0], 8'h00);
    repeat (4) @(posedge clk_sys_in);
    $display("test idle cycle done");
    check({1'b0, 8'(exp_q.size())}, 9'h000);
    tally_and_finish();
  end
endmodule
`default_nettype wire

/* shared/cmbi_map.svh */
// constants for the processor memory bus interface
// assumes a single 100 MHz system clock
`ifndef CMBI_MAP_SVH
`define CMBI_MAP_SVH
// machine cycle of eight clock pulses
`define CMBI_CYC_LEN 4'h8
`define CMBI_CYC_LAST 3'h7
// phase positions inside a machine cycle
`define CMBI_PH_ALP_ON 3'h1
`define CMBI_PH_ALP_OFF 3'h2
`define CMBI_PH_RD_ON 3'h2
`define CMBI_PH_WR_ON 3'h4
`define CMBI_PH_WR_OFF 3'h6
`define CMBI_HI_MSB 15
`define CMBI_HI_LSB 8
`define CMBI_LO_MSB 7
`define CMBI_LO_LSB 0
`define CMBI_BYTE_ZERO 8'h00
`define CMBI_PH_ZERO 3'h0
`endif

/* shared/cmbi_pkg.sv */
// types for the processor memory bus interface
// assumes cmbi_map.svh for numeric constants
package cmbi_pkg;
  typedef enum logic [1:0] {
    CMBI_OP_NONE,
    CMBI_OP_READ,
    CMBI_OP_WRITE
  } cmbi_op_t;
  typedef enum logic [1:0] {
    CMBI_DST_INT,
    CMBI_DST_IO
  } cmbi_dst_t;
endpackage

/* verilog/cmbi_mem_if.sv */
// memory bus interface of the processor core
// assumes an external upper address latch and static memory on the pins
`timescale 1ns/1ps
`default_nettype none
`include "cmbi_map.svh"
module cmbi_mem_if (
  input wire logic clk_sys_in,
  input wire logic rst_in,
  input wire logic req_in,
  input wire cmbi_pkg::cmbi_op_t op_in,
  input wire cmbi_pkg::cmbi_dst_t dst_in,
  input wire logic [15:0] addr_in,
  input wire logic [7:0] wdata_in,
  input wire logic [7:0] bus_data_in,
  output logic busy_out,
  output logic [7:0] multiplexed_address_lines_out,
  output logic address_latch_pulse_out,
  output logic memory_read_enable_n_out,
  output logic memory_write_strobe_n_out,
  output logic [7:0] bus_data_out,
  output logic bus_data_oe_n_out,
  output logic [7:0] int_data_out,
  output logic int_valid_out,
  output logic [7:0] io_data_out,
  output logic io_valid_out
);
  // ****************************************
  // cycle capture
  // ****************************************
  logic [2:0] phase;
  logic last;
  logic active_q;
  logic [15:0] addr_q;
  logic [7:0] wdata_q;
  cmbi_pkg::cmbi_op_t op_q;
  cmbi_pkg::cmbi_dst_t dst_q;
  logic [7:0] bus_s1_q;
  logic [7:0] bus_s2_q;
  logic start;
  assign start = req_in && !active_q;
  cmbi_phase u_phase (
    .clk_sys_in(clk_sys_in),
    .rst_in(rst_in),
    .run_in(start),
    .phase_out(phase),
    .last_out(last)
  );
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      active_q <= 1'b0;
      addr_q <= 16'h0000;
      wdata_q <= `CMBI_BYTE_ZERO;
      op_q <= cmbi_pkg::CMBI_OP_NONE;
      dst_q <= cmbi_pkg::CMBI_DST_INT;
    end else if (start) begin
      active_q <= 1'b1;
      addr_q <= addr_in;
      wdata_q <= wdata_in;
      op_q <= op_in;
      dst_q <= dst_in;
    end else if (active_q && last) begin
      active_q <= 1'b0;
    end
  end
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      busy_out <= 1'b0;
    end else begin
      busy_out <= start || (active_q && !last);
    end
  end
  // ****************************************
  // address multiplexing
  // ****************************************
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      multiplexed_address_lines_out <= `CMBI_BYTE_ZERO;
    end else if (start) begin
      multiplexed_address_lines_out <= addr_in[`CMBI_HI_MSB:`CMBI_HI_LSB];
    end else if (active_q && phase == `CMBI_PH_ALP_OFF) begin
      multiplexed_address_lines_out <= addr_q[`CMBI_LO_MSB:`CMBI_LO_LSB];
    end
  end
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      address_latch_pulse_out <= 1'b0;
    end else begin
      // pulse falls one clock before the lower byte replaces the upper one
      address_latch_pulse_out <= start;
    end
  end
  // ****************************************
  // strobes and data
  // ****************************************
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      memory_read_enable_n_out <= 1'b1;
    end else if (active_q && op_q == cmbi_pkg::CMBI_OP_READ
                 && phase == `CMBI_PH_RD_ON) begin
      memory_read_enable_n_out <= 1'b0;
    end else if (last) begin
      memory_read_enable_n_out <= 1'b1;
    end
  end
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      memory_write_strobe_n_out <= 1'b1;
    end else if (active_q && op_q == cmbi_pkg::CMBI_OP_WRITE
                 && phase == `CMBI_PH_WR_ON) begin
      memory_write_strobe_n_out <= 1'b0;
    end else if (phase == `CMBI_PH_WR_OFF) begin
      memory_write_strobe_n_out <= 1'b1;
    end
  end
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      bus_data_out <= `CMBI_BYTE_ZERO;
      bus_data_oe_n_out <= 1'b1;
    end else if (active_q && op_q == cmbi_pkg::CMBI_OP_WRITE
                 && phase == `CMBI_PH_RD_ON) begin
      bus_data_out <= wdata_q;
      bus_data_oe_n_out <= 1'b0;
    end else if (last) begin
      bus_data_oe_n_out <= 1'b1;
    end
  end
  // ****************************************
  // read data routing
  // ****************************************
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      bus_s1_q <= `CMBI_BYTE_ZERO;
      bus_s2_q <= `CMBI_BYTE_ZERO;
    end else begin
      bus_s1_q <= bus_data_in;
      bus_s2_q <= bus_s1_q;
    end
  end
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      int_data_out <= `CMBI_BYTE_ZERO;
      io_data_out <= `CMBI_BYTE_ZERO;
      int_valid_out <= 1'b0;
      io_valid_out <= 1'b0;
    end else begin
      int_valid_out <= 1'b0;
      io_valid_out <= 1'b0;
      if (active_q && last && op_q == cmbi_pkg::CMBI_OP_READ) begin
        if (dst_q == cmbi_pkg::CMBI_DST_IO) begin
          io_data_out <= bus_s2_q;
          io_valid_out <= 1'b1;
        end else begin
          int_data_out <= bus_s2_q;
          int_valid_out <= 1'b1;
        end
      end
    end
  end
  // ****************************************
  // checks
  // ****************************************
  AST_HI_FIRST: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    start |=> multiplexed_address_lines_out ==
      $past(addr_in[`CMBI_HI_MSB:`CMBI_HI_LSB]))
    else $error("upper byte not shown first");
  AST_PULSE_HI: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    address_latch_pulse_out |->
      multiplexed_address_lines_out == addr_q[`CMBI_HI_MSB:`CMBI_HI_LSB])
    else $error("latch pulse without upper byte");
  AST_LO_AFTER: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    $fell(address_latch_pulse_out) |=>
      multiplexed_address_lines_out == addr_q[`CMBI_LO_MSB:`CMBI_LO_LSB])
    else $error("lower byte not shown after latch");
  AST_NO_BOTH: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    !(memory_read_enable_n_out == 1'b0 && memory_write_strobe_n_out == 1'b0))
    else $error("read and write together");
  AST_IDLE_HIGH: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    !active_q && !busy_out |-> memory_read_enable_n_out && memory_write_strobe_n_out)
    else $error("strobe low while idle");
  AST_WR_DATA: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    !memory_write_strobe_n_out |-> !bus_data_oe_n_out && bus_data_out == wdata_q)
    else $error("write pulse without data");
  AST_WR_WIDTH: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    $fell(memory_write_strobe_n_out) |-> !memory_write_strobe_n_out [*2] ##1
      memory_write_strobe_n_out)
    else $error("write pulse width wrong");
  AST_RD_HOLD: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    $fell(memory_read_enable_n_out) |-> !memory_read_enable_n_out [*5] ##1
      memory_read_enable_n_out)
    else $error("read strobe not held");
  AST_RD_ROUTE: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    $rose(memory_read_enable_n_out) |-> (int_valid_out ^ io_valid_out))
    else $error("read byte not routed");
endmodule
`default_nettype wire

/* verilog/cmbi_phase.sv */
// machine cycle phase counter
// assumes one clock; wraps to zero eight clocks after run_in and holds there
`timescale 1ns/1ps
`default_nettype none
`include "cmbi_map.svh"
module cmbi_phase (
  input wire logic clk_sys_in,
  input wire logic rst_in,
  input wire logic run_in,
  output logic [2:0] phase_out,
  output logic last_out
);
  // ****************************************
  // phase count
  // ****************************************
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      phase_out <= `CMBI_PH_ZERO;
    end else if (run_in || phase_out != `CMBI_PH_ZERO) begin
      phase_out <= phase_out + 3'h1;
    end
  end
  assign last_out = (phase_out == `CMBI_CYC_LAST);
endmodule
`default_nettype wire
